// ---- rtl/nta_params.svh ----
// Constants of the contactless activation block: command codes, answer
// bytes, field positions and timing counts.
// Assumes a 50 MHz core clock.
`ifndef NTA_PARAMS_SVH
`define NTA_PARAMS_SVH

`define NTA_CMD_ALL      8'h52
`define NTA_CMD_SENS     8'h26
`define NTA_CMD_SLP      8'h50
`define NTA_SLP_ARG      8'h00
`define NTA_SEL_CL1      8'h93
`define NTA_SEL_CL2      8'h95
`define NTA_NVB_SDD      8'h20
`define NTA_NVB_SEL      8'h70
`define NTA_CASCADE_TAG  8'h88
`define NTA_ATQA0        8'h42
`define NTA_ATQA1        8'h00
`define NTA_SAK_CL1      8'h04
`define NTA_SAK_CL2      8'h20
`define NTA_CMD_RATS     8'hE0
`define NTA_ATS_TL       8'h05
`define NTA_ATS_T0_HI    4'h7
`define NTA_FSCI         4'h5
`define NTA_ATS_TA       8'h80
`define NTA_FWI          4'h6
`define NTA_SFGI         4'h0
`define NTA_ATS_TC       8'h02
`define NTA_PPSS_HI      4'hD
`define NTA_PPS0         8'h11
`define NTA_DES          8'hC2
`define NTA_DES_CID      8'hCA
`define NTA_DID_MAX      4'hE
`define NTA_MAX_CMD      7'd64
`define NTA_LEN_SAT      7'd65
`define NTA_BUF_BYTES    7'd7
`define NTA_RATE_106     2'b00
`define NTA_CLK_NS       20
`define NTA_FWT_NS       19200000
`define NTA_FWT_CYC      (`NTA_FWT_NS / `NTA_CLK_NS)

`endif

// ---- rtl/nta_pkg.sv ----
// Types of the contactless activation block.
// Constants live in nta_params.svh.
package nta_pkg;

    typedef enum logic [2:0] {
        NTA_IDLE   = 3'h0,
        NTA_READY1 = 3'h1,
        NTA_READY2 = 3'h3,
        NTA_ACTIVE = 3'h2,
        NTA_PROT   = 3'h6,
        NTA_HALT   = 3'h4
    } nta_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       eof;
        logic       short_f;
        logic       crc_ok;
    } nta_rx_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
        logic       crc;
    } nta_tx_t;

    typedef struct packed {
        nta_state_t      state;
        logic [6:0]      len;
        logic [6:0][7:0] rbuf;
        logic [4:0][7:0] resp;
        logic [2:0]      tx_cnt;
        logic [2:0]      tx_len;
        nta_tx_t         tx;
        logic [19:0]     fwt_cnt;
        logic [3:0]      did;
        logic [8:0]      fsd;
        logic            pps_ok;
        logic            rate_pend;
        logic [1:0]      new_asc;
        logic [1:0]      new_desc;
        logic [1:0]      rate_asc;
        logic [1:0]      rate_desc;
        logic            session;
        logic [2:0]      fld_sync;
        logic            fld;
    } nta_regs_t;

endpackage : nta_pkg

// ---- rtl/nta_activation.sv ----
// Tag-side activation logic: request, anticollision, RATS/ATS, PPS and
// the deselect that ends a session.
// Assumes a byte framer on core_clk that checks and appends CRC_A.
//
// Functional notes
// - Recognise ALL 52h, SENS 26h short frames, SLP 50h, codes 93h/95h.
// - Answer SENS in IDLE, or ALL in IDLE or HALT, with ATQA bytes 42h 00h.
// - Hold a 7-byte identifier; answer SDD with the requested level's part.
// - Each SDD answer is four level bytes plus their XOR check byte.
// - Level 1 sends 88h and bytes 1-3; level 2 sends bytes 4-7.
// - Matching level-1 SEL gets SAK 04h with CRC.
// - Matching level-2 SEL gets SAK 20h with CRC.
// - FSDI 0-8 decode to 16..256 bytes; 9-E reserved; F means 256.
// - After a nonzero DID is assigned, ignore commands with another DID.
// - ATS is 05h 75h 80h 60h plus option byte, then CRC.
// - ATS advertises receive frame code 5, meaning 64 bytes.
// - Commands above 64 bytes are discarded without any reply.
// - FWI 6 gives 19.2 ms frame waiting time bounding the answer.
// - ATS option byte says dynamic ID is supported.
// - PPS is optional; only 106 kbit/s in both directions.
// - Rate code 00 is 106 kbit/s; reply to PPS only if both apply.
// - Send PPS reply at old rate, then switch to negotiated rates.
// - Session closes on deselect block or loss of the RF field.
`timescale 1ns/10ps
`include "nta_params.svh"

module nta_activation
    import nta_pkg::*;
#(
    parameter logic [6:0][7:0] NFCID1  = 56'h06_05_04_03_02_01_00,
    parameter int              FWT_CYC = `NTA_FWT_CYC
) (
    input  wire logic       core_clk,     // 50 MHz core clock
    input  wire logic       rst_b,        // Asynchronous reset, active low
    input  wire logic       ce,           // Clock enable, freezes all state
    input  wire logic       field_det,    // RF field present, asynchronous
    input  wire nta_rx_t    rx,           // Received bytes and frame end
    input  wire logic       tx_ready,     // Framer takes the current byte
    output nta_tx_t         tx,           // Answer bytes to the framer
    output nta_state_t      tag_state,    // Activation state
    output logic            session_open, // Applicative session open
    output logic [3:0]      did_out,      // Assigned dynamic ID
    output logic [8:0]      fsd_out,      // Reader frame size in bytes
    output logic [1:0]      rate_asc,     // Reader-to-tag rate code
    output logic [1:0]      rate_desc     // Tag-to-reader rate code
);

    // The identifier value above is arbitrary.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // =====================================================================
    // Helper functions
    // =====================================================================
    function automatic logic [7:0] bcc4(input logic [3:0][7:0] b);
        bcc4 = b[0] ^ b[1] ^ b[2] ^ b[3];
    endfunction : bcc4

    function automatic logic [8:0] fsd_of(input logic [3:0] fsdi);
        unique case (fsdi)
            4'h0:    fsd_of = 9'h010;
            4'h1:    fsd_of = 9'h018;
            4'h2:    fsd_of = 9'h020;
            4'h3:    fsd_of = 9'h028;
            4'h4:    fsd_of = 9'h030;
            4'h5:    fsd_of = 9'h040;
            4'h6:    fsd_of = 9'h060;
            4'h7:    fsd_of = 9'h080;
            default: fsd_of = 9'h100;
        endcase
    endfunction : fsd_of

    function automatic logic rate_ok(input logic [1:0] code);
        rate_ok = (code == `NTA_RATE_106);
    endfunction : rate_ok

    // =====================================================================
    // Frame decode
    // =====================================================================
    nta_regs_t       s;
    nta_regs_t       next_s;
    logic [3:0][7:0] lvl;
    logic [7:0]      b0, b1, b2;
    logic            no_crc, d_acc, d_code, d_all, d_sens, d_sdd;
    logic            d_sel, d_slp, d_rats, d_pps, d_des, d_iblk;
    logic            d_didok, tx_done;

    assign b0 = s.rbuf[0];
    assign b1 = s.rbuf[1];
    assign b2 = s.rbuf[2];
    assign lvl = (s.state == NTA_READY1) ?
        {NFCID1[2], NFCID1[1], NFCID1[0], `NTA_CASCADE_TAG} :
        {NFCID1[6], NFCID1[5], NFCID1[4], NFCID1[3]};
    assign no_crc = rx.short_f || (s.len == 7'd2 && b1 == `NTA_NVB_SDD);
    assign d_acc = ce && rx.eof && !s.tx.valid && s.fld
                   && s.len != 7'd0 && s.len <= `NTA_MAX_CMD
                   && (no_crc || rx.crc_ok);
    assign d_all = d_acc && rx.short_f && s.len == 7'd1
                   && {1'b0, b0[6:0]} == `NTA_CMD_ALL;
    assign d_sens = d_acc && rx.short_f && s.len == 7'd1
                    && {1'b0, b0[6:0]} == `NTA_CMD_SENS;
    assign d_code = (s.state == NTA_READY1 && b0 == `NTA_SEL_CL1)
                    || (s.state == NTA_READY2 && b0 == `NTA_SEL_CL2);
    assign d_sdd = d_acc && d_code && s.len == 7'd2
                   && b1 == `NTA_NVB_SDD;
    assign d_sel = d_acc && d_code && s.len == 7'd7
                   && b1 == `NTA_NVB_SEL && s.rbuf[5:2] == lvl
                   && s.rbuf[6] == bcc4(lvl);
    assign d_slp = d_acc && !rx.short_f && s.len == 7'd2
                   && b0 == `NTA_CMD_SLP && b1 == `NTA_SLP_ARG;
    assign d_rats = d_acc && s.state == NTA_ACTIVE && s.len == 7'd2
                    && b0 == `NTA_CMD_RATS
                    && b1[3:0] <= `NTA_DID_MAX;
    assign d_didok = !b0[3] || b1[3:0] == s.did;
    assign d_pps = d_acc && s.state == NTA_PROT && s.pps_ok
                   && s.len == 7'd3 && b0[7:4] == `NTA_PPSS_HI
                   && b0[3:0] == s.did && b1 == `NTA_PPS0
                   && b2[7:4] == 4'h0
                   && rate_ok(b2[3:2]) && rate_ok(b2[1:0]);
    assign d_des = d_acc && s.state == NTA_PROT
                   && ((b0 == `NTA_DES && s.len == 7'd1)
                       || (b0 == `NTA_DES_CID && s.len == 7'd2
                           && d_didok));
    assign d_iblk = d_acc && s.state == NTA_PROT && b0[7:6] == 2'b00
                    && d_didok;
    assign tx_done = s.tx.valid && s.tx.last && tx_ready;

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        logic [4:0][7:0] r;
        logic [2:0]      rl;
        logic            go;
        logic            crc;
        r   = '0;
        rl  = 3'd0;
        go  = 1'b0;
        crc = 1'b0;
        next_s = s;
        next_s.fld_sync = {s.fld_sync[1:0], field_det};
        if (s.fld_sync[2] == s.fld_sync[1]) begin
            next_s.fld = s.fld_sync[2];
        end

        // Answer bytes leave one at a time while the framer is ready.
        if (s.tx.valid) begin
            if (tx_ready) begin
                next_s.fwt_cnt = 20'd0;
                if (s.tx.last) begin
                    next_s.tx.valid = 1'b0;
                    if (s.rate_pend) begin
                        next_s.rate_pend = 1'b0;
                        next_s.rate_asc  = s.new_asc;
                        next_s.rate_desc = s.new_desc;
                    end
                end else begin
                    next_s.tx_cnt  = s.tx_cnt + 3'd1;
                    next_s.tx.data = s.resp[s.tx_cnt + 3'd1];
                    next_s.tx.last = (s.tx_cnt + 3'd1 == s.tx_len);
                end
            end else if (s.tx_cnt == 3'd0) begin
                // An answer not started within the waiting time is dropped.
                if (s.fwt_cnt == 20'(FWT_CYC - 1)) begin
                    next_s.tx.valid = 1'b0;
                    next_s.rate_pend = 1'b0;
                    next_s.fwt_cnt = 20'd0;
                end else begin
                    next_s.fwt_cnt = s.fwt_cnt + 20'd1;
                end
            end
        end else if (rx.valid) begin
            if (s.len < `NTA_BUF_BYTES) begin
                next_s.rbuf[s.len[2:0]] = rx.data;
            end
            if (s.len != `NTA_LEN_SAT) begin
                next_s.len = s.len + 7'd1;
            end
        end

        if (rx.eof && !s.tx.valid) begin
            next_s.len = 7'd0;
        end

        if (d_acc) begin
            unique case (s.state)
                NTA_IDLE, NTA_HALT: begin
                    if (d_all || (d_sens && s.state == NTA_IDLE)) begin
                        r[0] = `NTA_ATQA0;
                        r[1] = `NTA_ATQA1;
                        rl = 3'd1;
                        go = 1'b1;
                        next_s.state = NTA_READY1;
                    end
                end
                NTA_READY1, NTA_READY2: begin
                    if (d_sdd) begin
                        r[3:0] = lvl;
                        r[4] = bcc4(lvl);
                        rl = 3'd4;
                        go = 1'b1;
                    end else if (d_sel) begin
                        r[0] = (s.state == NTA_READY1) ?
                               `NTA_SAK_CL1 : `NTA_SAK_CL2;
                        crc = 1'b1;
                        go = 1'b1;
                        next_s.state = (s.state == NTA_READY1) ?
                                       NTA_READY2 : NTA_ACTIVE;
                    end else begin
                        next_s.state = NTA_IDLE;
                    end
                end
                NTA_ACTIVE: begin
                    if (d_slp) begin
                        next_s.state = NTA_HALT;
                    end else if (d_rats) begin
                        r[0] = `NTA_ATS_TL;
                        r[1] = {`NTA_ATS_T0_HI, `NTA_FSCI};
                        r[2] = `NTA_ATS_TA;
                        r[3] = {`NTA_FWI, `NTA_SFGI};
                        r[4] = `NTA_ATS_TC;
                        rl = 3'd4;
                        crc = 1'b1;
                        go = 1'b1;
                        next_s.did = b1[3:0];
                        next_s.fsd = fsd_of(b1[7:4]);
                        next_s.pps_ok = 1'b1;
                        next_s.state = NTA_PROT;
                    end else begin
                        next_s.state = NTA_IDLE;
                    end
                end
                NTA_PROT: begin
                    if (d_pps) begin
                        r[0] = b0;
                        crc = 1'b1;
                        go = 1'b1;
                        next_s.pps_ok = 1'b0;
                        next_s.rate_pend = 1'b1;
                        next_s.new_desc = b2[3:2];
                        next_s.new_asc = b2[1:0];
                    end else if (d_des) begin
                        r[0] = b0;
                        r[1] = b1;
                        rl = (s.len == 7'd2) ? 3'd1 : 3'd0;
                        crc = 1'b1;
                        go = 1'b1;
                        next_s.session = 1'b0;
                        next_s.state = NTA_HALT;
                    end else if (d_iblk) begin
                        next_s.session = 1'b1;
                        next_s.pps_ok = 1'b0;
                    end
                end
                default: next_s.state = NTA_IDLE;
            endcase
        end

        if (go) begin
            next_s.resp     = r;
            next_s.tx_len   = rl;
            next_s.tx_cnt   = 3'd0;
            next_s.fwt_cnt  = 20'd0;
            next_s.tx.valid = 1'b1;
            next_s.tx.data  = r[0];
            next_s.tx.last  = (rl == 3'd0);
            next_s.tx.crc   = crc;
        end

        // Losing the field drops state, session, DID, PPS and rates back to power-up values; fsd keeps its value.
        if (!s.fld) begin
            next_s.state     = NTA_IDLE;
            next_s.session   = 1'b0;
            next_s.tx.valid  = 1'b0;
            next_s.len       = 7'd0;
            next_s.did       = 4'h0;
            next_s.pps_ok    = 1'b0;
            next_s.rate_pend = 1'b0;
            next_s.rate_asc  = `NTA_RATE_106;
            next_s.rate_desc = `NTA_RATE_106;
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign tx           = s.tx;
    assign tag_state    = s.state;
    assign session_open = s.session;
    assign did_out      = s.did;
    assign fsd_out      = s.fsd;
    assign rate_asc     = s.rate_asc;
    assign rate_desc    = s.rate_desc;

    // =====================================================================
    // Assertions
    // =====================================================================
    property p_atqa;
        (d_all && s.state == NTA_HALT) |=> (tx.valid
            && tx.data == 8'h42 && !tx.crc && s.resp[1] == 8'h00
            && s.state == NTA_READY1);
    endproperty
    a_atqa: assert property (p_atqa) else $error("bad ATQA");
    property p_sdd_len;
        (d_sdd && s.fld) |=> (s.tx_len == 3'd4 && tx.valid && !tx.crc);
    endproperty
    a_sdd_len: assert property (p_sdd_len) else $error("SDD len");
    property p_bcc;
        (d_sdd && s.fld) |=> (s.resp[4] ==
            (s.resp[0] ^ s.resp[1] ^ s.resp[2] ^ s.resp[3]));
    endproperty
    a_bcc: assert property (p_bcc) else $error("bad check byte");
    property p_ct;
        (d_sdd && s.fld && s.state == NTA_READY1)
            |=> (tx.data == 8'h88 && s.resp[1] == NFCID1[0]);
    endproperty
    a_ct: assert property (p_ct) else $error("level 1 answer");
    property p_sak1;
        (d_sel && s.fld && s.state == NTA_READY1) |=> (tx.data == 8'h04
            && tx.crc && tx.last && s.state == NTA_READY2);
    endproperty
    a_sak1: assert property (p_sak1) else $error("SAK level 1");
    property p_sak2;
        (d_sel && s.fld && s.state == NTA_READY2) |=> (tx.data == 8'h20
            && tx.crc && s.state == NTA_ACTIVE);
    endproperty
    a_sak2: assert property (p_sak2) else $error("SAK level 2");
    property p_long;
        (ce && rx.eof && !s.tx.valid && s.len > 7'd64)
            |=> !tx.valid [*2];
    endproperty
    a_long: assert property (p_long) else $error("long frame answered");
    property p_ats;
        (d_rats && s.fld) |=> (tx.data == 8'h05 && s.tx_len == 3'd4
            && s.resp[1] == 8'h75 && s.resp[3] == 8'h60 && tx.crc);
    endproperty
    a_ats: assert property (p_ats) else $error("bad ATS");
    property p_rate;
        (s.rate_pend && !(ce && tx_done)) |=> $stable(rate_asc)
            && $stable(rate_desc);
    endproperty
    a_rate: assert property (p_rate) else $error("early rate switch");
    property p_halt;
        (s.state == NTA_HALT && s.fld && !d_all) |=> s.state == NTA_HALT;
    endproperty
    a_halt: assert property (p_halt) else $error("left halt");

endmodule : nta_activation

// ---- test/nta_reader.sv ----
// Reader model: sends frames to the tag and collects its answers.
// Assumes the byte framer interface of nta_pkg and one shared clock.
`timescale 1ns/10ps
module nta_reader
    import nta_pkg::*;
#(
    parameter int GUARD = 4
) (
    input  wire logic    core_clk, // Core clock
    input  wire nta_tx_t tx,       // Answer bytes from the tag
    input  wire logic    stall,    // Reader holds off taking answers
    output nta_rx_t      rx,       // Frame bytes towards the tag
    output logic         tx_ready  // Current answer byte taken
);
    // ==========
    // Answer collection
    logic [7:0] ans[$];
    logic       ans_crc = 1'b0;
    logic       done = 1'b0;

    initial rx = '0;
    initial tx_ready = 1'b0;
    always @(negedge core_clk) tx_ready <= tx.valid & ~stall;
    always @(posedge core_clk) begin
        if (tx.valid && tx_ready) begin
            ans.push_back(tx.data);
            ans_crc = tx.crc;
            done = tx.last;
        end
    end

    // ==========
    // Frame sending
    task automatic send(input logic [7:0] fr[$], input logic sh,
                        input logic ok);
        int i;
        repeat (GUARD) @(negedge core_clk);
        ans.delete();
        ans_crc = 1'b0;
        done = 1'b0;
        for (i = 0; i < fr.size(); i++) begin
            @(negedge core_clk);
            rx.valid = 1'b1;
            rx.data = fr[i];
        end
        @(negedge core_clk);
        rx.valid = 1'b0;
        rx.data = ~rx.data;
        rx.eof = 1'b1;
        rx.short_f = sh;
        rx.crc_ok = ok;
        @(negedge core_clk);
        rx.eof = 1'b0;
        rx.data = ~rx.data;
    endtask : send
endmodule : nta_reader

// ---- test/tb_top.sv ----
// Testbench of the activation block: the reader model sends frames and
// each scenario judges the answers and the status outputs.
// Assumes nta_pkg compiled first and a 50 MHz core clock.
`timescale 1ns/10ps
module tb_top
    import nta_pkg::*;
;
    // ==========
    // Signals
    localparam logic [6:0][7:0] ID = 56'h17_26_35_44_53_62_71;
    localparam logic [7:0] B1 = 8'h88 ^ ID[0] ^ ID[1] ^ ID[2];
    localparam logic [7:0] B2 = ID[3] ^ ID[4] ^ ID[5] ^ ID[6];
    localparam logic [8:0] FSD [16] = '{9'h010, 9'h018, 9'h020, 9'h028,
        9'h030, 9'h040, 9'h060, 9'h080, 9'h100, 9'h100, 9'h100, 9'h100,
        9'h100, 9'h100, 9'h100, 9'h100};
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       field_det = 1'b1;
    logic       stall = 1'b0;
    logic       ce = 1'b1;
    int         bad_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    logic [7:0] nil[$], a1[$], a2[$], s1[$], s2[$], ats[$];
    nta_rx_t    rx;
    nta_tx_t    tx;
    nta_state_t tag_state;
    logic       tx_ready, session_open;
    logic [3:0] did_out;
    logic [8:0] fsd_out;
    logic [1:0] rate_asc, rate_desc;

    nta_activation #(.NFCID1(ID), .FWT_CYC(16)) nta_activation_inst (
        .core_clk(core_clk), .rst_b(rst_b), .ce(ce),
        .field_det(field_det), .rx(rx), .tx_ready(tx_ready), .tx(tx),
        .tag_state(tag_state), .session_open(session_open),
        .did_out(did_out), .fsd_out(fsd_out), .rate_asc(rate_asc),
        .rate_desc(rate_desc));
    nta_reader nta_reader_inst (.core_clk(core_clk), .tx(tx),
        .stall(stall), .rx(rx), .tx_ready(tx_ready));

    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    // ==========
    // Shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] fr[$], input logic sh,
        input logic ok, input logic [7:0] e[$], input logic c);
        int i;
        nta_reader_inst.send(fr, sh, ok);
        for (i = 0; i < 40 && nta_reader_inst.done !== 1'b1; i++)
            @(negedge core_clk);
        chk(16'(nta_reader_inst.ans.size()), 16'(e.size()));
        for (i = 0; i < e.size() && i < nta_reader_inst.ans.size(); i++)
            chk({8'h00, nta_reader_inst.ans[i]}, {8'h00, e[i]});
        chk({15'h0, nta_reader_inst.ans_crc}, {15'h0, c});
    endtask : xfer

    task automatic activate(input logic [7:0] req, input logic [7:0] par,
                            input logic rats);
        xfer('{req}, 1, 1, '{8'h42, 8'h00}, 0);
        xfer('{8'h93, 8'h20}, 0, 0, a1, 0);
        xfer(s1, 0, 1, '{8'h04}, 1);
        xfer('{8'h95, 8'h20}, 0, 0, a2, 0);
        xfer(s2, 0, 1, '{8'h20}, 1);
        if (rats)
            xfer('{8'hE0, par}, 0, 1, ats, 1);
    endtask : activate

    task automatic field_cycle();
        field_det = 1'b0;
        repeat (6) @(negedge core_clk);
        chk(16'({session_open, did_out, tag_state}), 16'h0000);
        field_det = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask : field_cycle

    // ==========
    // Scenarios
    task automatic t_prot();
        activate(8'h26, 8'h81, 1);
        chk(16'(fsd_out), 16'(FSD[8]));
        chk(16'(did_out), 16'h0001);
        xfer('{8'hD1, 8'h11, 8'h01}, 0, 1, nil, 0);
        xfer('{8'hD2, 8'h11, 8'h00}, 0, 1, nil, 0);
        xfer('{8'hD1, 8'h11, 8'h00}, 0, 1, '{8'hD1}, 1);
        chk(16'({rate_asc, rate_desc}), 16'h0000);
        xfer('{8'h0A, 8'h02, 8'h00}, 0, 1, nil, 0);
        chk(16'(session_open), 16'h0000);
        xfer('{8'h0A, 8'h01, 8'h00}, 0, 1, nil, 0);
        chk(16'(session_open), 16'h0001);
        xfer('{8'hCA, 8'h01}, 0, 1, '{8'hCA, 8'h01}, 1);
        chk(16'({session_open, tag_state}), 16'h0004);
    endtask : t_prot

    task automatic t_halt();
        int f;
        xfer('{8'h26}, 1, 1, nil, 0);
        activate(8'h52, 8'h00, 0);
        xfer('{8'h50, 8'h00}, 0, 1, nil, 0);
        chk(16'(tag_state), 16'h0004);
        for (f = 0; f < 16; f++) begin
            activate(8'h52, {f[3:0], 4'h0}, 1);
            chk(16'(fsd_out), 16'(FSD[f]));
            xfer('{8'hC2}, 0, 1, '{8'hC2}, 1);
        end
    endtask : t_halt

    task automatic t_fault();
        int i;
        logic [7:0] big[$];
        activate(8'h52, 8'h83, 0);
        xfer('{8'hE0, 8'h0F}, 0, 1, nil, 0);
        chk(16'(tag_state), 16'h0000);
        activate(8'h26, 8'h83, 1);
        for (i = 0; i < 65; i++)
            big.push_back(8'h02);
        xfer(big, 0, 1, nil, 0);
        chk(16'(session_open), 16'h0000);
        void'(big.pop_back());
        xfer(big, 0, 1, nil, 0);
        chk(16'(session_open), 16'h0001);
        field_cycle();
        xfer('{8'h26}, 1, 1, '{8'h42, 8'h00}, 0);
        xfer(s1, 0, 0, nil, 0);
        field_cycle();
        stall = 1'b1;
        xfer('{8'h52}, 1, 1, nil, 0);
        chk(16'(tx.valid), 16'h0000);
        stall = 1'b0;
        ce = 1'b0;
        field_det = 1'b0;
        repeat (8) @(negedge core_clk);
        chk(16'(tag_state), 16'h0001);
        ce = 1'b1;
        repeat (6) @(negedge core_clk);
        chk(16'(tag_state), 16'h0000);
        field_det = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask : t_fault

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    initial begin
        a1 = '{8'h88, ID[0], ID[1], ID[2], B1};
        a2 = '{ID[3], ID[4], ID[5], ID[6], B2};
        s1 = '{8'h93, 8'h70, 8'h88, ID[0], ID[1], ID[2], B1};
        s2 = '{8'h95, 8'h70, ID[3], ID[4], ID[5], ID[6], B2};
        ats = '{8'h05, 8'h75, 8'h80, 8'h60, 8'h02};
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge core_clk);
        t_prot();
        t_halt();
        t_fault();
        close_out();
    end
endmodule : tb_top
